/* File: hdl/phyan_top.sv */
`timescale 1ns/1ns
// Overview of operation
// R01: strap enable low forces 10/100 and half/full from the two select straps
// R02: strap enable high picks the advertised ability set from the select straps
// R03: straps sampled after reset load advertisement bits 8 to 5
// R04: basic control writes override the strapped configuration at any time
// R05: advertisement word is sent as FLP bursts; any ability mix allowed
// R06: resolve common abilities 100 full, 100 half, 10 full, 10 half
// R07: speed and duplex bits act only while negotiation is disabled
// R08: phy status summary shows resolved speed once link is up
// R09: ability bits read constant ones, 100BASE-T4 reads zero
// R10: basic status shows complete, remote fault, link, preamble suppression
// R11: advertisement defaults to all abilities, software may clear any
// R12: partner register holds received pages, 0081h or 0021h after parallel detect
// R13: expansion shows pd fault, partner and local next page, page rx, partner able
// R14: both receivers feed parallel detection of a non negotiating partner
// R15: parallel detect sets bit 5 or 7, selector 00001, partner able zero
// R16: parallel detect fault set unless exactly one good link; the code sets it only when both links are good
// R17: restart bit 9 restarts negotiation at any time
// R18: lost link after negotiation resumes negotiation
// R19: renegotiation silences the line for the break link time, then FLP
// R20: after forced strapping, software clears then sets bit 12 to negotiate
// R21: auto crossover on by default, strap or bits 15:14, random, not forced
// R22: bit 14 forces crossover regardless of negotiation or auto crossover
// R23: every management register is 16 bits wide
module phyan_top #(
  parameter int BREAK_CYCLES = phyan_pkg::BREAK_LINK_CYC,
  parameter int MDIX_SLOT = phyan_pkg::MDIX_SLOT_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire phyan_pkg::phyan_strap_t STRAPS,
  input wire logic LINK10_GOOD,
  input wire logic LINK100_GOOD,
  input wire logic PAGE_TOGGLE,
  input wire logic [15:0] PAGE_WORD,
  output logic TX_FLP_EN,
  output logic TX_SILENT,
  output logic [15:0] TX_WORD,
  output logic LINK_UP,
  output phyan_pkg::phyan_mode_t LINK_MODE,
  output logic CROSSOVER
);
  import phyan_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [22:0] sync1_ff;
  logic [22:0] sync2_ff;
  logic pg_tog_d_ff;
  phyan_strap_t strap_s;
  logic link10_s;
  logic link100_s;
  logic [15:0] pg_word_s;
  logic pg_evt;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      pg_tog_d_ff <= 1'b0;
    end else begin
      sync1_ff <= {STRAPS, LINK10_GOOD, LINK100_GOOD, PAGE_TOGGLE, PAGE_WORD};
      sync2_ff <= sync1_ff;
      pg_tog_d_ff <= sync2_ff[16];
    end
  end

  assign strap_s = phyan_strap_t'(sync2_ff[22:19]);
  assign link10_s = sync2_ff[18];
  assign link100_s = sync2_ff[17];
  assign pg_word_s = sync2_ff[15:0];

  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  logic [1:0] boot_cnt_ff;
  logic boot_done_ff;
  logic load_now;
  logic [3:0] strap_adv;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      boot_cnt_ff <= 2'h0;
      boot_done_ff <= 1'b0;
    end else if (!boot_done_ff) begin
      if (boot_cnt_ff == BOOT_WAIT) begin
        boot_done_ff <= 1'b1;
      end else begin
        boot_cnt_ff <= boot_cnt_ff + 2'h1;
      end
    end
  end

  // waiting lets the synchroniser fill before straps are trusted
  assign load_now = !boot_done_ff && (boot_cnt_ff == BOOT_WAIT);

  // a page is flagged by a toggle so it survives any pulse width; held off until the
  // synchroniser has filled, so a toggle left high across reset is no false page
  assign pg_evt = (sync2_ff[16] ^ pg_tog_d_ff) && boot_done_ff;

  always_comb begin
    case ({strap_s.neg_en, strap_s.sel_hi, strap_s.sel_lo})
      3'h0: strap_adv = 4'h1; // R01
      3'h1: strap_adv = 4'h2; // R01
      3'h2: strap_adv = 4'h4; // R01
      3'h3: strap_adv = 4'h8; // R01
      3'h4: strap_adv = 4'h3; // R02
      3'h5: strap_adv = 4'hc; // R02
      3'h6: strap_adv = 4'h5; // R02
      default: strap_adv = ADV_ALL; // R02
    endcase
  end

  // ----------------------------------------
  // wishbone slave decode
  // ----------------------------------------
  logic ack_ff;
  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic [5:0] idx;
  logic [15:0] wd;

  assign bus_req = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wr_en = bus_req && WB_WE_I;
  assign rd_en = bus_req && !WB_WE_I;
  assign idx = WB_ADR_I[7:2];

  // lanes above 15 are dropped, registers are 16 bits
  always_comb begin
    wd = 16'h0000;
    if (WB_SEL_I[0]) begin
      wd[7:0] = WB_DAT_I[7:0]; // R23
    end
    if (WB_SEL_I[1]) begin
      wd[15:8] = WB_DAT_I[15:8]; // R23
    end
  end

  logic wr_ctrl;
  logic wr_adv;
  logic wr_pc;
  assign wr_ctrl = wr_en && (idx == BASIC_CTRL_IDX) && WB_SEL_I[1];
  assign wr_adv = wr_en && (idx == ADVERT_IDX);
  assign wr_pc = wr_en && (idx == PHY_CTRL_IDX) && WB_SEL_I[1];

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic neg_en_ff;
  logic speed_ff;
  logic duplex_ff;
  logic forced_boot_ff;
  logic arm_ff;
  logic neg_en_d_ff;
  logic reneg_ff;
  logic [3:0] adv_ff;
  logic autox_ff;
  logic forcex_ff;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      neg_en_ff <= 1'b0;
      speed_ff <= 1'b0;
      duplex_ff <= 1'b0;
      forced_boot_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else if (load_now) begin
      neg_en_ff <= strap_s.neg_en; // R01
      speed_ff <= strap_s.sel_hi; // R01
      duplex_ff <= strap_s.sel_lo; // R01
      forced_boot_ff <= !strap_s.neg_en;
      arm_ff <= 1'b0;
    end else if (wr_ctrl) begin
      speed_ff <= wd[CTL_SPEED_BIT]; // R04
      duplex_ff <= wd[CTL_DUPLEX_BIT]; // R04
      if (!wd[CTL_NEG_EN_BIT]) begin
        neg_en_ff <= 1'b0;
        arm_ff <= 1'b1;
      end else if (!forced_boot_ff || arm_ff) begin
        neg_en_ff <= 1'b1; // R20
      end
    end
  end

  // restart is self clearing; enabling negotiation counts as a request too
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      neg_en_d_ff <= 1'b0;
      reneg_ff <= 1'b0;
    end else begin
      neg_en_d_ff <= neg_en_ff;
      reneg_ff <= (wr_ctrl && wd[CTL_RESTART_BIT]) || (neg_en_ff && !neg_en_d_ff); // R17
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      adv_ff <= ADV_ALL; // R11
    end else if (load_now) begin
      adv_ff <= strap_adv; // R03
    end else if (wr_adv) begin
      // the ability field straddles both lanes; an unselected lane keeps its bits
      if (WB_SEL_I[1]) begin
        adv_ff[3] <= wd[ADV_MSB]; // R11
      end
      if (WB_SEL_I[0]) begin
        adv_ff[2:0] <= wd[ADV_MSB-1:ADV_LSB]; // R11
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      autox_ff <= 1'b1; // R21
      forcex_ff <= 1'b0;
    end else if (load_now) begin
      autox_ff <= strap_s.autox; // R21
    end else if (wr_pc) begin
      autox_ff <= wd[PC_AUTOX_BIT]; // R21
      forcex_ff <= wd[PC_FORCEX_BIT]; // R22
    end
  end

  // ----------------------------------------
  // negotiation state machine
  // ----------------------------------------
  phyan_state_t state_ff;
  logic [31:0] tmr_ff;
  logic [11:0] pd_cnt_ff;
  logic [15:0] partner_ff;
  logic partner_able_ff;
  logic complete_ff;
  logic link_ff;
  phyan_mode_t mode_ff;
  logic [3:0] common;
  logic res_ok;
  phyan_mode_t res_mode;
  logic cur_link;

  assign common = adv_ff & pg_word_s[ADV_MSB:ADV_LSB];
  assign cur_link = mode_ff.spd100 ? link100_s : link10_s;

  always_comb begin
    res_ok = 1'b1;
    res_mode = '{spd100: 1'b0, full: 1'b0};
    if (common[3]) begin
      res_mode = '{spd100: 1'b1, full: 1'b1}; // R06
    end else if (common[2]) begin
      res_mode = '{spd100: 1'b1, full: 1'b0}; // R06
    end else if (common[1]) begin
      res_mode = '{spd100: 1'b0, full: 1'b1}; // R06
    end else if (!common[0]) begin
      res_ok = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_ff <= ST_FORCED;
      tmr_ff <= 32'h0;
      pd_cnt_ff <= 12'h000;
      partner_ff <= 16'h0000;
      partner_able_ff <= 1'b0;
      complete_ff <= 1'b0;
      link_ff <= 1'b0;
      mode_ff <= '0;
    end else if (!neg_en_ff) begin
      state_ff <= ST_FORCED;
      mode_ff <= '{spd100: speed_ff, full: duplex_ff}; // R07
      link_ff <= speed_ff ? link100_s : link10_s;
      complete_ff <= 1'b0;
    end else if (reneg_ff) begin
      state_ff <= ST_BREAK; // R19
      tmr_ff <= 32'h0;
      link_ff <= 1'b0;
      complete_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_FORCED: begin
          state_ff <= ST_BREAK;
          tmr_ff <= 32'h0;
        end
        ST_BREAK: begin
          tmr_ff <= tmr_ff + 32'h1;
          if (tmr_ff == 32'(BREAK_CYCLES - 1)) begin
            state_ff <= ST_ABILITY; // R19
            pd_cnt_ff <= 12'h000;
          end
        end
        ST_ABILITY: begin
          link_ff <= 1'b0;
          if (pg_evt) begin
            partner_ff <= pg_word_s; // R12
            partner_able_ff <= 1'b1;
            if (res_ok) begin
              mode_ff <= res_mode; // R06
              complete_ff <= 1'b1;
              state_ff <= ST_DONE;
            end
          end else if (link10_s ^ link100_s) begin
            pd_cnt_ff <= pd_cnt_ff + 12'h001; // R14
            if (pd_cnt_ff == PD_SETTLE_CYC - 12'h001) begin
              partner_ff <= link100_s ? PD_100_WORD : PD_10_WORD; // R15
              partner_able_ff <= 1'b0; // R15
              mode_ff <= '{spd100: link100_s, full: 1'b0}; // R14
              complete_ff <= 1'b1;
              state_ff <= ST_DONE;
            end
          end else begin
            pd_cnt_ff <= 12'h000;
          end
        end
        ST_DONE: begin
          link_ff <= cur_link;
          if (pg_evt) begin
            partner_ff <= pg_word_s; // R12
          end
          if (link_ff && !cur_link) begin
            state_ff <= ST_ABILITY; // R18
            complete_ff <= 1'b0;
            pd_cnt_ff <= 12'h000;
          end
        end
        default: state_ff <= ST_FORCED;
      endcase
    end
  end

  // ----------------------------------------
  // sticky expansion flags, cleared by reading, set wins
  // ----------------------------------------
  logic pd_fault_ff;
  logic page_rx_ff;
  logic rd_exp;
  logic in_neg;
  assign rd_exp = rd_en && (idx == EXPAN_IDX);
  assign in_neg = neg_en_ff && !reneg_ff;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pd_fault_ff <= 1'b0;
      page_rx_ff <= 1'b0;
    end else begin
      if (in_neg && state_ff == ST_ABILITY && link10_s && link100_s) begin
        pd_fault_ff <= 1'b1; // R16
      end else if (rd_exp) begin
        pd_fault_ff <= 1'b0;
      end
      if (in_neg && pg_evt && (state_ff == ST_ABILITY || state_ff == ST_DONE)) begin
        page_rx_ff <= 1'b1; // R13
      end else if (rd_exp) begin
        page_rx_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // crossover selection
  // ----------------------------------------
  logic [15:0] lfsr_ff;
  logic [31:0] slot_ff;
  logic xover_ff;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      lfsr_ff <= LFSR_SEED;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
    end
  end

  // random flips break the lock-step that two identical ends would fall into
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      slot_ff <= 32'h0;
      xover_ff <= 1'b0;
    end else if (forcex_ff) begin
      xover_ff <= 1'b1; // R22
      slot_ff <= 32'h0;
    end else if (!autox_ff || !neg_en_ff) begin
      xover_ff <= 1'b0; // R21
      slot_ff <= 32'h0;
    end else if (!link_ff) begin
      slot_ff <= slot_ff + 32'h1;
      if (slot_ff == 32'(MDIX_SLOT - 1)) begin
        slot_ff <= 32'h0;
        if (lfsr_ff[0]) begin
          xover_ff <= !xover_ff; // R21
        end
      end
    end
  end

  // ----------------------------------------
  // line side outputs
  // ----------------------------------------
  logic flp_ff;
  logic silent_ff;
  logic [15:0] tx_word_ff;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      flp_ff <= 1'b0;
      silent_ff <= 1'b0;
      tx_word_ff <= 16'h0000;
    end else begin
      flp_ff <= neg_en_ff && (state_ff == ST_ABILITY); // R05
      silent_ff <= neg_en_ff && (state_ff == ST_BREAK); // R19
      tx_word_ff <= {7'h00, adv_ff, SELECTOR_8023}; // R05
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [15:0] rd_val;
  logic [31:0] rdata_ff;

  always_comb begin
    rd_val = 16'h0000;
    case (idx)
      BASIC_CTRL_IDX: begin
        rd_val[CTL_SPEED_BIT] = speed_ff;
        rd_val[CTL_NEG_EN_BIT] = neg_en_ff;
        rd_val[CTL_DUPLEX_BIT] = duplex_ff;
      end
      BASIC_STAT_IDX: begin
        rd_val = BASIC_STAT_FIXED; // R09
        rd_val[ST_COMPLETE_BIT] = complete_ff; // R10
        rd_val[ST_RFAULT_BIT] = partner_able_ff && partner_ff[PTR_RFAULT_BIT]; // R10
        rd_val[ST_LINK_BIT] = link_ff; // R10
      end
      ADVERT_IDX: rd_val = {7'h00, adv_ff, SELECTOR_8023};
      PARTNER_IDX: rd_val = partner_ff; // R12
      EXPAN_IDX: begin
        rd_val[EX_PD_FAULT_BIT] = pd_fault_ff; // R13
        rd_val[EX_PTR_NP_BIT] = partner_able_ff && partner_ff[PTR_NEXT_PAGE_BIT]; // R13
        rd_val[EX_PAGE_RX_BIT] = page_rx_ff; // R13
        rd_val[EX_PTR_ABLE_BIT] = partner_able_ff; // R15
      end
      PHY_STAT_IDX: begin
        rd_val[PS_LINK_BIT] = link_ff; // R08
        rd_val[PS_SPEED10_BIT] = !mode_ff.spd100; // R08
        rd_val[PS_FULL_BIT] = mode_ff.full; // R08
        rd_val[PS_COMPLETE_BIT] = complete_ff;
        rd_val[PS_XOVER_BIT] = xover_ff;
      end
      PHY_CTRL_IDX: begin
        rd_val[PC_AUTOX_BIT] = autox_ff;
        rd_val[PC_FORCEX_BIT] = forcex_ff;
      end
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rdata_ff <= 32'h0;
    end else if (rd_en) begin
      rdata_ff <= {16'h0000, rd_val}; // R23
    end
  end

  assign WB_DAT_O = rdata_ff;
  assign WB_ACK_O = ack_ff;
  assign TX_FLP_EN = flp_ff;
  assign TX_SILENT = silent_ff;
  assign TX_WORD = tx_word_ff;
  assign LINK_UP = link_ff;
  assign LINK_MODE = mode_ff;
  assign CROSSOVER = xover_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  AST_STRAP_LOAD: assert property (load_now |=> adv_ff == $past(strap_adv)) // R03
    else $error("straps not loaded into advertisement");
  AST_FORCED_SPEED: assert property (!neg_en_ff && !$past(neg_en_ff) |=> LINK_MODE.spd100 == $past(speed_ff)) // R07
    else $error("forced speed not applied");
  AST_PRIORITY: assert property (in_neg && state_ff == ST_ABILITY && pg_evt && res_ok |=> mode_ff == $past(res_mode)) // R06
    else $error("wrong resolved mode");
  AST_BREAK_QUIET: assert property (in_neg && state_ff == ST_BREAK |=> TX_SILENT && !TX_FLP_EN) // R19
    else $error("line not silent during break");
  AST_BREAK_LEN: assert property ($past(state_ff) == ST_BREAK && state_ff == ST_ABILITY
    |-> $past(tmr_ff) == 32'(BREAK_CYCLES - 1)) // R19
    else $error("break link time wrong");
  AST_PD_WORD: assert property ($past(state_ff) == ST_ABILITY && state_ff == ST_DONE && !partner_able_ff
    |-> partner_ff == PD_100_WORD || partner_ff == PD_10_WORD) // R15
    else $error("bad parallel detect partner word");
  AST_PD_FAULT: assert property (in_neg && state_ff == ST_ABILITY && link10_s && link100_s |=> pd_fault_ff) // R16
    else $error("parallel detect fault missed");
  AST_FORCE_XOVER: assert property (forcex_ff |=> CROSSOVER) // R22
    else $error("forced crossover not applied");
  AST_NO_AUTOX: assert property (!forcex_ff && !neg_en_ff |=> !CROSSOVER) // R21
    else $error("crossover active in forced mode");
  AST_RESUME: assert property (in_neg && state_ff == ST_DONE && link_ff && !cur_link |=> state_ff == ST_ABILITY) // R18
    else $error("no resume after link loss");
  AST_STAT_FIXED: assert property (rd_en && idx == BASIC_STAT_IDX |=> WB_ACK_O && WB_DAT_O[15:11] == 5'h0f) // R09
    else $error("ability bits wrong");

  COV_NEGOTIATED: cover property (state_ff == ST_DONE && partner_able_ff && link_ff);
  COV_PARALLEL: cover property (state_ff == ST_DONE && !partner_able_ff);
  COV_RESTART: cover property ($past(state_ff) == ST_DONE && state_ff == ST_BREAK);
  COV_XOVER_FLIP: cover property (!forcex_ff && $changed(CROSSOVER));
endmodule

/* File: hdl/phyan_pkg.sv */
package phyan_pkg;
  // ----------------------------------------
  // register indices, byte address is index times four
  // ----------------------------------------
  localparam logic [5:0] BASIC_CTRL_IDX = 6'h00;
  localparam logic [5:0] BASIC_STAT_IDX = 6'h01;
  localparam logic [5:0] ADVERT_IDX = 6'h04;
  localparam logic [5:0] PARTNER_IDX = 6'h05;
  localparam logic [5:0] EXPAN_IDX = 6'h06;
  localparam logic [5:0] PHY_STAT_IDX = 6'h10;
  localparam logic [5:0] PHY_CTRL_IDX = 6'h19;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTL_SPEED_BIT = 13;
  localparam int CTL_NEG_EN_BIT = 12;
  localparam int CTL_RESTART_BIT = 9;
  localparam int CTL_DUPLEX_BIT = 8;
  localparam int ADV_LSB = 5;
  localparam int ADV_MSB = 8;
  localparam int ST_COMPLETE_BIT = 5;
  localparam int ST_RFAULT_BIT = 4;
  localparam int ST_LINK_BIT = 2;
  localparam int PTR_NEXT_PAGE_BIT = 15;
  localparam int PTR_RFAULT_BIT = 13;
  localparam int EX_PD_FAULT_BIT = 4;
  localparam int EX_PTR_NP_BIT = 3;
  localparam int EX_PAGE_RX_BIT = 1;
  localparam int EX_PTR_ABLE_BIT = 0;
  localparam int PS_LINK_BIT = 0;
  localparam int PS_SPEED10_BIT = 1;
  localparam int PS_FULL_BIT = 2;
  localparam int PS_COMPLETE_BIT = 4;
  localparam int PS_XOVER_BIT = 14;
  localparam int PC_AUTOX_BIT = 15;
  localparam int PC_FORCEX_BIT = 14;

  // ----------------------------------------
  // fixed and reset values
  // ----------------------------------------
  localparam logic [4:0] SELECTOR_8023 = 5'h01;
  localparam logic [15:0] PD_100_WORD = 16'h0081;
  localparam logic [15:0] PD_10_WORD = 16'h0021;
  localparam logic [15:0] BASIC_STAT_FIXED = 16'h7849;
  localparam logic [3:0] ADV_ALL = 4'hf;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [1:0] BOOT_WAIT = 2'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BREAK_LINK_MS = 1500;
  localparam int BREAK_LINK_CYC = BREAK_LINK_MS * CLK_MHZ * 1000;
  localparam int MDIX_SLOT_MS = 62;
  localparam int MDIX_SLOT_CYC = MDIX_SLOT_MS * CLK_MHZ * 1000;
  localparam int PD_SETTLE_US = 8;
  localparam logic [11:0] PD_SETTLE_CYC = 12'(PD_SETTLE_US * CLK_MHZ);

  typedef enum logic [1:0] {ST_FORCED, ST_BREAK, ST_ABILITY, ST_DONE} phyan_state_t;

  typedef struct packed {
    logic spd100;
    logic full;
  } phyan_mode_t;

  typedef struct packed {
    logic neg_en;
    logic sel_hi;
    logic sel_lo;
    logic autox;
  } phyan_strap_t;
endpackage

/* File: verification/phyan_partner.sv */
`timescale 1ns/1ns
// ------
// link partner: receiver link levels and code words
// ------
module phyan_partner (
  input wire logic clk,
  input wire logic send,
  input wire logic [15:0] word,
  input wire logic [1:0] links,
  output logic link10,
  output logic link100,
  output logic toggle,
  output logic [15:0] page
);
  logic [3:0] cnt_ff = 4'h0;
  initial begin
    toggle = 1'b0;
    page = 16'h0000;
    link10 = 1'b0;
    link100 = 1'b0;
  end
  // word stands well around the toggle, then is inverted so a stale page never reads as valid
  always @(posedge clk) begin
    {link100, link10} <= links;
    if (send && cnt_ff == 4'h0) begin
      page <= word;
      cnt_ff <= 4'h1;
    end else if (cnt_ff == 4'h5) begin
      toggle <= ~toggle;
      cnt_ff <= 4'h6;
    end else if (cnt_ff == 4'h9) begin
      page <= ~page;
      cnt_ff <= 4'h0;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

/* File: verification/phyan_top_tb.sv */
`timescale 1ns/1ns
// ------
// bench: strap table, negotiation, parallel detect, crossover
// ------
module phyan_top_tb;
  import phyan_pkg::*;
  logic clk, rst, cyc, stb, we, ack, send, flp, silent, lnk, xov, l10, l100, tog;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o;
  logic [15:0] word, pw, txw;
  logic [1:0] links;
  phyan_strap_t straps;
  phyan_mode_t mode;
  int err_count = 0;
  int tests_run = 0;
  logic [3:0] adv_tab [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h5, 4'hf};

  // short break and slot so the run stays small
  phyan_top #(.BREAK_CYCLES(20), .MDIX_SLOT(16)) phyan_top_inst (.SYS_CLK(clk), .RST(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .STRAPS(straps), .LINK10_GOOD(l10),
    .LINK100_GOOD(l100), .PAGE_TOGGLE(tog), .PAGE_WORD(pw), .TX_FLP_EN(flp), .TX_SILENT(silent),
    .TX_WORD(txw), .LINK_UP(lnk), .LINK_MODE(mode), .CROSSOVER(xov));
  phyan_partner phyan_partner_inst (.clk(clk), .send(send), .word(word), .links(links),
    .link10(l10), .link100(l100), .toggle(tog), .page(pw));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ack is awaited with no assumed latency; only the bound guards a hang
  task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    dat <= {16'h0000, d};
    sel <= 4'h3;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 64) chk(16'h0000, 16'h0001, "no ack");
    @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, a, 16'h0000, q);
    chk(q & m, e, "read");
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic boot(input phyan_strap_t s);
    rst <= 1'b1;
    straps <= s;
    tick(20);
    rst <= 1'b0;
    tick(8);
  endtask

  task automatic send_page(input logic [15:0] w);
    word <= w;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    tick(20);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    {rst, cyc, stb, we, send, links, adr, sel, dat, word} = '0;
    straps = '0;
    rst = 1'b1;
    for (int i = 0; i < 8; i++) begin
      boot({i[2:0], 1'b1});
      rd(ADVERT_IDX, 16'hffff, {7'h00, adv_tab[i], 5'h01});
      if (i < 4) chk({14'h0000, mode}, {14'h0000, i[1:0]}, "forced mode");
    end
    rd(BASIC_STAT_IDX, 16'hf849, BASIC_STAT_FIXED);
    rd(PHY_CTRL_IDX, 16'h8000, 16'h8000);
    rd(6'h02, 16'hffff, 16'h0000);
    tick(40);
    chk({15'h0000, flp}, 16'h0001, "flp");
    chk(txw, 16'h01e1, "tx word");
    wr(ADVERT_IDX, 16'h00a1);
    rd(ADVERT_IDX, 16'hffff, 16'h00a1);
    chk(txw, 16'h00a1, "tx word");
    links <= 2'b10;
    send_page(16'h01e1);
    chk({14'h0000, mode}, 16'h0002, "resolved");
    chk({15'h0000, lnk}, 16'h0001, "link");
    rd(PHY_STAT_IDX, 16'h0017, 16'h0011);
    rd(PARTNER_IDX, 16'hffff, 16'h01e1);
    rd(BASIC_STAT_IDX, 16'h0034, 16'h0024);
    rd(EXPAN_IDX, 16'h001f, 16'h0003);
    wr(BASIC_CTRL_IDX, 16'h1100);
    chk({14'h0000, mode}, 16'h0002, "ctl ignored");
    links <= 2'b00;
    tick(10);
    chk({14'h0000, flp, lnk}, 16'h0002, "link loss");
    wr(ADVERT_IDX, 16'h01e1);
    links <= 2'b01;
    tick(2100);
    chk({14'h0000, mode}, 16'h0000, "pd 10");
    rd(PARTNER_IDX, 16'hffff, PD_10_WORD);
    rd(EXPAN_IDX, 16'h001f, 16'h0000);
    rd(BASIC_STAT_IDX, 16'h0020, 16'h0020);
    links <= 2'b11;
    wr(BASIC_CTRL_IDX, 16'h1200);
    tick(2);
    chk({14'h0000, flp, silent}, 16'h0001, "break");
    tick(2100);
    rd(EXPAN_IDX, 16'h0010, 16'h0010);
    chk({14'h0000, flp, lnk}, 16'h0002, "no pd");
    links <= 2'b10;
    tick(2100);
    rd(PARTNER_IDX, 16'hffff, PD_100_WORD);
    chk({14'h0000, mode}, 16'h0002, "pd 100");
    wr(BASIC_CTRL_IDX, 16'h2100);
    wr(PHY_CTRL_IDX, 16'h8000);
    tick(100);
    chk({14'h0000, mode}, 16'h0003, "sw forced");
    chk({15'h0000, xov}, 16'h0000, "auto in forced");
    wr(PHY_CTRL_IDX, 16'hc000);
    tick(4);
    chk({15'h0000, xov}, 16'h0001, "force cross");
    boot(4'b0000);
    wr(BASIC_CTRL_IDX, 16'h1000);
    tick(40);
    chk({14'h0000, flp, silent}, 16'h0000, "set only");
    wr(BASIC_CTRL_IDX, 16'h0000);
    wr(BASIC_CTRL_IDX, 16'h1000);
    tick(40);
    chk({15'h0000, flp}, 16'h0001, "clear then set");
    summarize();
  end
endmodule
